// ---- verilog/bpr_pkg.sv ----
package bpr_pkg;

	// ************************************************************
	// Host access ports
	// ************************************************************
	localparam logic [15:0] IO_INDEX_PORT = 16'h03CE;
	localparam logic [15:0] IO_DATA_PORT = 16'h03CF;
	localparam int MM_ADDR_W = 8;

	// ************************************************************
	// Slots: memory-mapped byte offsets, also storage index
	// ************************************************************
	localparam int NUM_SLOTS = 23;
	localparam logic [4:0] OFS_BG0 = 5'h00;
	localparam logic [4:0] OFS_BG1 = 5'h01;
	localparam logic [4:0] OFS_BG2 = 5'h02;
	localparam logic [4:0] OFS_BG3 = 5'h03;
	localparam logic [4:0] OFS_FG0 = 5'h04;
	localparam logic [4:0] OFS_FG1 = 5'h05;
	localparam logic [4:0] OFS_FG2 = 5'h06;
	localparam logic [4:0] OFS_FG3 = 5'h07;
	localparam logic [4:0] OFS_WIDTH_LO = 5'h08;
	localparam logic [4:0] OFS_WIDTH_HI = 5'h09;
	localparam logic [4:0] OFS_HEIGHT_LO = 5'h0A;
	localparam logic [4:0] OFS_HEIGHT_HI = 5'h0B;
	localparam logic [4:0] OFS_DPITCH_LO = 5'h0C;
	localparam logic [4:0] OFS_DPITCH_HI = 5'h0D;
	localparam logic [4:0] OFS_SPITCH_LO = 5'h0E;
	localparam logic [4:0] OFS_SPITCH_HI = 5'h0F;
	localparam logic [4:0] OFS_DSTART_B0 = 5'h10;
	localparam logic [4:0] OFS_DSTART_B1 = 5'h11;
	localparam logic [4:0] OFS_DSTART_B2 = 5'h12;
	localparam logic [4:0] OFS_HOLE = 5'h13;
	localparam logic [4:0] OFS_SSTART_B0 = 5'h14;
	localparam logic [4:0] OFS_SSTART_B1 = 5'h15;
	localparam logic [4:0] OFS_SSTART_B2 = 5'h16;

	// ************************************************************
	// Indexed-port codes
	// ************************************************************
	localparam logic [7:0] IDX_BG0 = 8'h00;
	localparam logic [7:0] IDX_FG0 = 8'h01;
	localparam logic [7:0] IDX_BG1 = 8'h10;
	localparam logic [7:0] IDX_FG1 = 8'h11;
	localparam logic [7:0] IDX_BG2 = 8'h12;
	localparam logic [7:0] IDX_FG2 = 8'h13;
	localparam logic [7:0] IDX_BG3 = 8'h14;
	localparam logic [7:0] IDX_FG3 = 8'h15;
	localparam logic [7:0] IDX_PARAM_FIRST = 8'h20;
	localparam logic [7:0] IDX_PARAM_LAST = 8'h2E;
	localparam logic [7:0] IDX_PARAM_BIAS = 8'h18;

	// ************************************************************
	// Field layout and reset values
	// ************************************************************
	localparam int WIDTH_W = 13;
	localparam int HEIGHT_W = 11;
	localparam int PITCH_W = 13;
	localparam int START_W = 22;
	localparam logic [7:0] SLOT_RESET = 8'h00;
	localparam logic [7:0] IDX_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic [31:0] COLOR_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		BPR_XW_8 = 2'h0,
		BPR_XW_16 = 2'h1,
		BPR_XW_24 = 2'h2,
		BPR_XW_32 = 2'h3
	} bpr_xwidth_t;

	// Index to slot: {valid, offset}
	function automatic logic [5:0] bpr_index_to_slot(input logic [7:0] idx);
		logic [7:0] rel;
		rel = idx - IDX_PARAM_BIAS;
		unique case (idx)
			IDX_BG0: bpr_index_to_slot = {1'b1, OFS_BG0};
			IDX_FG0: bpr_index_to_slot = {1'b1, OFS_FG0};
			IDX_BG1: bpr_index_to_slot = {1'b1, OFS_BG1};
			IDX_FG1: bpr_index_to_slot = {1'b1, OFS_FG1};
			IDX_BG2: bpr_index_to_slot = {1'b1, OFS_BG2};
			IDX_FG2: bpr_index_to_slot = {1'b1, OFS_FG2};
			IDX_BG3: bpr_index_to_slot = {1'b1, OFS_BG3};
			IDX_FG3: bpr_index_to_slot = {1'b1, OFS_FG3};
			default: begin
				if (idx >= IDX_PARAM_FIRST && idx <= IDX_PARAM_LAST && rel[4:0] != OFS_HOLE) begin
					bpr_index_to_slot = {1'b1, rel[4:0]};
				end else begin
					bpr_index_to_slot = 6'h00;
				end
			end
		endcase
	endfunction

endpackage

// ---- verilog/bpr_color_steer.sv ----
`timescale 1ns/1ps
`default_nettype none

module bpr_color_steer (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic [1:0] i_expand_width,
	input wire logic [31:0] i_fg_bytes,
	input wire logic [31:0] i_bg_bytes,
	output logic [31:0] o_fg_color,
	output logic [31:0] o_bg_color
);

	logic [31:0] fg_r;
	logic [31:0] fg_nxt;
	logic [31:0] bg_r;
	logic [31:0] bg_nxt;

	// Byte lanes that a width draws on; unused lanes read as zero
	function automatic logic [31:0] lane_mask(input logic [1:0] w, input logic is_bg);
		unique case (w)
			bpr_pkg::BPR_XW_8: lane_mask = 32'h0000_00FF;
			bpr_pkg::BPR_XW_16: lane_mask = 32'h0000_FFFF;
			bpr_pkg::BPR_XW_24: lane_mask = is_bg ? 32'h0000_0000 : 32'h00FF_FFFF;
			bpr_pkg::BPR_XW_32: lane_mask = 32'hFFFF_FFFF;
		endcase
	endfunction

	always_comb begin
		fg_nxt = i_fg_bytes & lane_mask(i_expand_width, 1'b0);
		bg_nxt = i_bg_bytes & lane_mask(i_expand_width, 1'b1);
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			fg_r <= bpr_pkg::COLOR_RESET;
			bg_r <= bpr_pkg::COLOR_RESET;
		end else begin
			fg_r <= fg_nxt;
			bg_r <= bg_nxt;
		end
	end

	assign o_fg_color = fg_r;
	assign o_bg_color = bg_r;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_fg8;
		@(posedge i_mclk) disable iff (i_srst)
		i_expand_width == 2'h0 |=> o_fg_color == {24'h000000, $past(i_fg_bytes[7:0])};
	endproperty
	a_fg8: assert property (p_fg8) else $error("8bpp fg wrong");

	property p_bg8;
		@(posedge i_mclk) disable iff (i_srst)
		i_expand_width == 2'h0 |=> o_bg_color == {24'h000000, $past(i_bg_bytes[7:0])};
	endproperty
	a_bg8: assert property (p_bg8) else $error("8bpp bg wrong");

	property p_fg16;
		@(posedge i_mclk) disable iff (i_srst)
		i_expand_width == 2'h1 |=> o_fg_color[31:16] == 16'h0000
			&& o_fg_color[15:8] == $past(i_fg_bytes[15:8]);
	endproperty
	a_fg16: assert property (p_fg16) else $error("16bpp fg wrong");

	property p_bg24;
		@(posedge i_mclk) disable iff (i_srst)
		i_expand_width == 2'h2 |=> o_bg_color == 32'h0000_0000
			&& o_fg_color[23:16] == $past(i_fg_bytes[23:16]);
	endproperty
	a_bg24: assert property (p_bg24) else $error("24bpp bg not idle");

	property p_c32;
		@(posedge i_mclk) disable iff (i_srst)
		i_expand_width == 2'h3 |=> o_bg_color == $past(i_bg_bytes)
			&& o_fg_color == $past(i_fg_bytes);
	endproperty
	a_c32: assert property (p_c32) else $error("32bpp colour wrong");

endmodule

`default_nettype wire

// ---- verilog/bpr_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

module bpr_regs #(
	parameter int MM_ADDR_W = bpr_pkg::MM_ADDR_W
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [15:0] i_io_addr,
	input wire logic [7:0] i_io_wdata,
	output logic [7:0] o_io_rdata,
	input wire logic i_mm_wr,
	input wire logic i_mm_rd,
	input wire logic [MM_ADDR_W-1:0] i_mm_addr,
	input wire logic [7:0] i_mm_wdata,
	output logic [7:0] o_mm_rdata,
	input wire logic [1:0] i_expand_width,
	output logic [31:0] o_fg_color,
	output logic [31:0] o_bg_color,
	output logic [12:0] o_width,
	output logic [13:0] o_width_bytes,
	output logic [10:0] o_height,
	output logic [11:0] o_height_lines,
	output logic [12:0] o_dst_pitch,
	output logic [12:0] o_src_pitch,
	output logic [21:0] o_dst_start,
	output logic [21:0] o_src_start
);

	// ************************************************************
	// Storage
	// ************************************************************
	logic [7:0] slot_r [0:bpr_pkg::NUM_SLOTS-1];
	logic [7:0] slot_nxt [0:bpr_pkg::NUM_SLOTS-1];
	logic [7:0] idx_r;
	logic [7:0] idx_nxt;
	logic [7:0] io_rdata_r;
	logic [7:0] io_rdata_nxt;
	logic [7:0] mm_rdata_r;
	logic [7:0] mm_rdata_nxt;

	logic [5:0] io_slot;
	logic io_idx_wr;
	logic io_idx_rd;
	logic io_data_wr;
	logic io_data_rd;
	logic mm_hit;
	logic [4:0] mm_slot;

	// ************************************************************
	// Decode
	// ************************************************************
	always_comb begin
		io_slot = bpr_pkg::bpr_index_to_slot(idx_r);
		io_idx_wr = i_io_wr && i_io_addr == bpr_pkg::IO_INDEX_PORT;
		io_idx_rd = i_io_rd && i_io_addr == bpr_pkg::IO_INDEX_PORT;
		io_data_wr = i_io_wr && i_io_addr == bpr_pkg::IO_DATA_PORT && io_slot[5];
		io_data_rd = i_io_rd && i_io_addr == bpr_pkg::IO_DATA_PORT;
		mm_slot = i_mm_addr[4:0];
		// Offsets past the last slot and the gap between the address triplets are unmapped
		mm_hit = i_mm_addr <= MM_ADDR_W'(bpr_pkg::OFS_SSTART_B2)
			&& mm_slot != bpr_pkg::OFS_HOLE;
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		slot_nxt = slot_r;
		idx_nxt = idx_r;
		io_rdata_nxt = io_rdata_r;
		mm_rdata_nxt = mm_rdata_r;
		if (io_idx_wr) begin
			idx_nxt = i_io_wdata;
		end
		// Values only change on a host write, never from engine activity
		if (io_data_wr) begin
			slot_nxt[io_slot[4:0]] = i_io_wdata;
		end
		// Memory-mapped write issued last, so it wins a same-slot collision
		if (i_mm_wr && mm_hit) begin
			slot_nxt[mm_slot] = i_mm_wdata;
		end
		if (io_idx_rd) begin
			io_rdata_nxt = idx_r;
		end else if (io_data_rd) begin
			io_rdata_nxt = io_slot[5] ? slot_r[io_slot[4:0]] : 8'h00;
		end
		if (i_mm_rd) begin
			mm_rdata_nxt = mm_hit ? slot_r[mm_slot] : 8'h00;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			for (int i = 0; i < bpr_pkg::NUM_SLOTS; i++) begin
				slot_r[i] <= bpr_pkg::SLOT_RESET;
			end
			idx_r <= bpr_pkg::IDX_RESET;
			io_rdata_r <= bpr_pkg::RDATA_RESET;
			mm_rdata_r <= bpr_pkg::RDATA_RESET;
		end else begin
			for (int i = 0; i < bpr_pkg::NUM_SLOTS; i++) begin
				slot_r[i] <= slot_nxt[i];
			end
			idx_r <= idx_nxt;
			io_rdata_r <= io_rdata_nxt;
			mm_rdata_r <= mm_rdata_nxt;
		end
	end

	assign o_io_rdata = io_rdata_r;
	assign o_mm_rdata = mm_rdata_r;

	// ************************************************************
	// Field assembly
	// ************************************************************
	// Upper spare bits are kept for read-back but dropped here
	assign o_width = {slot_r[bpr_pkg::OFS_WIDTH_HI][4:0], slot_r[bpr_pkg::OFS_WIDTH_LO]};
	assign o_width_bytes = {1'b0, o_width} + 14'h0001;
	assign o_height = {slot_r[bpr_pkg::OFS_HEIGHT_HI][2:0], slot_r[bpr_pkg::OFS_HEIGHT_LO]};
	assign o_height_lines = {1'b0, o_height} + 12'h001;
	assign o_dst_pitch = {slot_r[bpr_pkg::OFS_DPITCH_HI][4:0],
		slot_r[bpr_pkg::OFS_DPITCH_LO]};
	assign o_src_pitch = {slot_r[bpr_pkg::OFS_SPITCH_HI][4:0],
		slot_r[bpr_pkg::OFS_SPITCH_LO]};
	assign o_dst_start = {slot_r[bpr_pkg::OFS_DSTART_B2][5:0], slot_r[bpr_pkg::OFS_DSTART_B1],
		slot_r[bpr_pkg::OFS_DSTART_B0]};
	// Pattern offset is simply the low bits of this value; the engine slices it
	assign o_src_start = {slot_r[bpr_pkg::OFS_SSTART_B2][5:0], slot_r[bpr_pkg::OFS_SSTART_B1],
		slot_r[bpr_pkg::OFS_SSTART_B0]};

	// ************************************************************
	// Colour steering
	// ************************************************************
	// 24bpp has no background lanes, so software must expand with transparency
	bpr_color_steer u_steer (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_expand_width(i_expand_width),
		.i_fg_bytes({slot_r[bpr_pkg::OFS_FG3], slot_r[bpr_pkg::OFS_FG2],
			slot_r[bpr_pkg::OFS_FG1], slot_r[bpr_pkg::OFS_FG0]}),
		.i_bg_bytes({slot_r[bpr_pkg::OFS_BG3], slot_r[bpr_pkg::OFS_BG2],
			slot_r[bpr_pkg::OFS_BG1], slot_r[bpr_pkg::OFS_BG0]}),
		.o_fg_color(o_fg_color),
		.o_bg_color(o_bg_color)
	);

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_io_width_lo_wr;
		io_data_wr && idx_r == 8'h20 && !(i_mm_wr && mm_hit && mm_slot == 5'h08);
	endsequence

	sequence s_mm_read_back;
		i_mm_rd && !i_mm_wr && mm_hit;
	endsequence

	sequence s_mm_write_hit;
		i_mm_wr && mm_hit;
	endsequence

	sequence s_mm_same_read;
		i_mm_rd && !i_mm_wr && i_mm_addr == $past(i_mm_addr);
	endsequence

	property p_io_write;
		@(posedge i_mclk) disable iff (i_srst)
		s_io_width_lo_wr |=> o_width[7:0] == $past(i_io_wdata);
	endproperty
	a_io_write: assert property (p_io_write) else $error("indexed write lost");

	property p_mm_write;
		@(posedge i_mclk) disable iff (i_srst)
		i_mm_wr && i_mm_addr == 8'h16 |=> o_src_start[21:16] == $past(i_mm_wdata[5:0]);
	endproperty
	a_mm_write: assert property (p_mm_write) else $error("mapped write lost");

	property p_read_back;
		@(posedge i_mclk) disable iff (i_srst)
		s_mm_write_hit ##1 s_mm_same_read |=> o_mm_rdata == $past(i_mm_wdata, 2);
	endproperty
	a_read_back: assert property (p_read_back) else $error("written byte not read back");

	property p_mm_rd;
		@(posedge i_mclk) disable iff (i_srst)
		s_mm_read_back |=> o_mm_rdata == $past(slot_r[mm_slot]);
	endproperty
	a_mm_rd: assert property (p_mm_rd) else $error("read-back mismatch");

	property p_width_bytes;
		@(posedge i_mclk) disable iff (i_srst)
		o_width == 13'h1FFF |-> o_width_bytes == 14'h2000;
	endproperty
	a_width_bytes: assert property (p_width_bytes) else $error("width max wrong");

	property p_width_hi;
		@(posedge i_mclk) disable iff (i_srst)
		io_data_wr && idx_r == 8'h21 && !(i_mm_wr && mm_hit)
			|=> o_width[12:8] == $past(i_io_wdata[4:0]);
	endproperty
	a_width_hi: assert property (p_width_hi) else $error("width upper bits wrong");

	property p_height;
		@(posedge i_mclk) disable iff (i_srst)
		i_mm_wr && i_mm_addr == 8'h0B |=> o_height[10:8] == $past(i_mm_wdata[2:0])
			&& o_height_lines == {1'b0, o_height} + 12'h001;
	endproperty
	a_height: assert property (p_height) else $error("height assembly wrong");

	property p_pitch;
		@(posedge i_mclk) disable iff (i_srst)
		i_mm_wr && i_mm_addr == 8'h0D && !io_data_wr |=> o_dst_pitch[12:8]
			== $past(i_mm_wdata[4:0]) && $stable(o_src_pitch);
	endproperty
	a_pitch: assert property (p_pitch) else $error("pitch assembly wrong");

	property p_dst_start;
		@(posedge i_mclk) disable iff (i_srst)
		i_mm_wr && i_mm_addr == 8'h12 |=> o_dst_start[21:16] == $past(i_mm_wdata[5:0]);
	endproperty
	a_dst_start: assert property (p_dst_start) else $error("destination start wrong");

	property p_hold;
		@(posedge i_mclk) disable iff (i_srst)
		!io_data_wr && !i_mm_wr |=> $stable(o_width) && $stable(o_height)
			&& $stable(o_dst_start) && $stable(o_src_start) && $stable(o_dst_pitch);
	endproperty
	a_hold: assert property (p_hold) else $error("parameter changed unwritten");

	property p_color_follow;
		@(posedge i_mclk) disable iff (i_srst)
		i_mm_wr && i_mm_addr == 8'h04 && i_expand_width == 2'h0 ##1 i_expand_width == 2'h0
			|=> o_fg_color[7:0] == $past(i_mm_wdata, 2);
	endproperty
	a_color_follow: assert property (p_color_follow) else $error("fg byte not used");

	property p_src_pitch;
		@(posedge i_mclk) disable iff (i_srst)
		i_mm_wr && i_mm_addr == 8'h0F |=> o_src_pitch[12:8] == $past(i_mm_wdata[4:0]);
	endproperty
	a_src_pitch: assert property (p_src_pitch) else $error("source pitch wrong");

	property p_src_lo;
		@(posedge i_mclk) disable iff (i_srst)
		io_data_wr && idx_r == 8'h2C && !(i_mm_wr && mm_hit)
			|=> o_src_start[7:0] == $past(i_io_wdata);
	endproperty
	a_src_lo: assert property (p_src_lo) else $error("source start low wrong");

	property p_dpitch_lo;
		@(posedge i_mclk) disable iff (i_srst)
		io_data_wr && idx_r == 8'h24 && !(i_mm_wr && mm_hit)
			|=> o_dst_pitch[7:0] == $past(i_io_wdata);
	endproperty
	a_dpitch_lo: assert property (p_dpitch_lo) else $error("destination pitch low wrong");

	property p_io_hole;
		@(posedge i_mclk) disable iff (i_srst)
		io_data_rd && idx_r == 8'h2B |=> o_io_rdata == 8'h00;
	endproperty
	a_io_hole: assert property (p_io_hole) else $error("unmapped index read not zero");

	property p_mm_hole;
		@(posedge i_mclk) disable iff (i_srst)
		i_mm_rd && i_mm_addr == 8'h13 |=> o_mm_rdata == 8'h00;
	endproperty
	a_mm_hole: assert property (p_mm_hole) else $error("unmapped offset read not zero");

	property p_idx_read;
		@(posedge i_mclk) disable iff (i_srst)
		io_idx_rd |=> o_io_rdata == $past(idx_r);
	endproperty
	a_idx_read: assert property (p_idx_read) else $error("index read-back wrong");

	property p_height_max;
		@(posedge i_mclk) disable iff (i_srst)
		o_height == 11'h7FF |-> o_height_lines == 12'h800;
	endproperty
	a_height_max: assert property (p_height_max) else $error("height max wrong");

	property p_rdata_hold;
		@(posedge i_mclk) disable iff (i_srst)
		!i_mm_rd |=> $stable(o_mm_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data not held");

endmodule

`default_nettype wire

// ---- tb/bpr_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module bpr_regs_test;

	// ************************************************************
	// Stimulus and design
	// ************************************************************
	logic i_mclk;
	logic i_srst;
	logic i_io_wr;
	logic i_io_rd;
	logic [15:0] i_io_addr;
	logic [7:0] i_io_wdata;
	logic [7:0] o_io_rdata;
	logic i_mm_wr;
	logic i_mm_rd;
	logic [7:0] i_mm_addr;
	logic [7:0] i_mm_wdata;
	logic [7:0] o_mm_rdata;
	logic [1:0] i_expand_width;
	logic [31:0] o_fg_color;
	logic [31:0] o_bg_color;
	logic [12:0] o_width;
	logic [13:0] o_width_bytes;
	logic [10:0] o_height;
	logic [11:0] o_height_lines;
	logic [12:0] o_dst_pitch;
	logic [12:0] o_src_pitch;
	logic [21:0] o_dst_start;
	logic [21:0] o_src_start;
	int fails;
	int checks;
	int cycles;
	logic [7:0] rd;

	// Own copy of the map so a slip in the design's decoder shows up
	localparam logic [7:0] IDX [22] = '{8'h00, 8'h10, 8'h12, 8'h14, 8'h01, 8'h11, 8'h13,
		8'h15, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A,
		8'h2C, 8'h2D, 8'h2E};
	localparam logic [7:0] OFS [22] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
		8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12,
		8'h14, 8'h15, 8'h16};

	bpr_regs bpr_regs_i (
		.i_mclk(i_mclk), .i_srst(i_srst), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
		.i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
		.i_mm_wr(i_mm_wr), .i_mm_rd(i_mm_rd), .i_mm_addr(i_mm_addr),
		.i_mm_wdata(i_mm_wdata), .o_mm_rdata(o_mm_rdata), .i_expand_width(i_expand_width),
		.o_fg_color(o_fg_color), .o_bg_color(o_bg_color), .o_width(o_width),
		.o_width_bytes(o_width_bytes), .o_height(o_height), .o_height_lines(o_height_lines),
		.o_dst_pitch(o_dst_pitch), .o_src_pitch(o_src_pitch), .o_dst_start(o_dst_start),
		.o_src_start(o_src_start)
	);

	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end

	// ************************************************************
	// Checking and closing
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Hang guard well above the few hundred cycles the tests need
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_sim();
		end
	end

	// ************************************************************
	// Access tasks: one-cycle strobes, idle cycle between accesses
	// ************************************************************
	task automatic io_pulse(input logic [15:0] a, input logic [7:0] d, input logic wr);
		@(negedge i_mclk);
		i_io_addr = a;
		i_io_wdata = d;
		i_io_wr = wr;
		i_io_rd = ~wr;
		@(negedge i_mclk);
		i_io_wr = 1'b0;
		i_io_rd = 1'b0;
	endtask

	task automatic io_wr(input logic [7:0] idx, input logic [7:0] d);
		io_pulse(bpr_pkg::IO_INDEX_PORT, idx, 1'b1);
		io_pulse(bpr_pkg::IO_DATA_PORT, d, 1'b1);
	endtask

	task automatic io_rd(input logic [7:0] idx, output logic [7:0] v);
		io_pulse(bpr_pkg::IO_INDEX_PORT, idx, 1'b1);
		io_pulse(bpr_pkg::IO_DATA_PORT, 8'h00, 1'b0);
		@(negedge i_mclk);
		v = o_io_rdata;
	endtask

	task automatic mm_pulse(input logic [7:0] a, input logic [7:0] d, input logic wr);
		@(negedge i_mclk);
		i_mm_addr = a;
		i_mm_wdata = d;
		i_mm_wr = wr;
		i_mm_rd = ~wr;
		@(negedge i_mclk);
		i_mm_wr = 1'b0;
		i_mm_rd = 1'b0;
	endtask

	task automatic mm_rd(input logic [7:0] a, output logic [7:0] v);
		mm_pulse(a, 8'h00, 1'b0);
		@(negedge i_mclk);
		v = o_mm_rdata;
	endtask

	// Writes width..source start bytes, then compares every assembled field
	task automatic fields(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] b2);
		for (int k = 8; k < 22; k++) begin
			mm_pulse(OFS[k], (k == 18 || k == 21) ? b2 : (OFS[k][0] ? hi : lo), 1'b1);
		end
		@(negedge i_mclk);
		check(32'(o_width), 32'({hi[4:0], lo}));
		check(32'(o_width_bytes), 32'({hi[4:0], lo}) + 32'h1);
		check(32'(o_height), 32'({hi[2:0], lo}));
		check(32'(o_height_lines), 32'({hi[2:0], lo}) + 32'h1);
		check(32'(o_dst_pitch), 32'({hi[4:0], lo}));
		check(32'(o_src_pitch), 32'({hi[4:0], lo}));
		check(32'(o_dst_start), 32'({b2[5:0], hi, lo}));
		check(32'(o_src_start), 32'({b2[5:0], hi, lo}));
		mm_rd(OFS[9], rd);
		check(32'(rd), 32'(hi));
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		fails = 0;
		checks = 0;
		cycles = 0;
		i_srst = 1'b1;
		{i_io_wr, i_io_rd, i_mm_wr, i_mm_rd} = 4'h0;
		i_io_addr = 16'h0000;
		i_io_wdata = 8'h00;
		i_mm_addr = 8'h00;
		i_mm_wdata = 8'h00;
		i_expand_width = 2'h0;
		repeat (3) @(negedge i_mclk);
		i_srst = 1'b0;

		for (int k = 0; k < 22; k++) begin
			mm_rd(OFS[k], rd);
			check(32'(rd), 32'h0);
		end
		check(32'(o_width_bytes), 32'h1);
		check(32'(o_height_lines), 32'h1);
		$display("Test reset values done");

		// Both paths reach the same byte, each direction
		for (int k = 0; k < 22; k++) begin
			io_wr(IDX[k], 8'hA0 ^ OFS[k]);
			mm_rd(OFS[k], rd);
			check(32'(rd), 32'(8'hA0 ^ OFS[k]));
			mm_pulse(OFS[k], 8'h3C ^ OFS[k], 1'b1);
			io_rd(IDX[k], rd);
			check(32'(rd), 32'(8'h3C ^ OFS[k]));
		end
		$display("Test dual access done");

		fields(8'hFF, 8'hFF, 8'hFF);
		fields(8'h5A, 8'hE3, 8'hC6);
		fields(8'h00, 8'h00, 8'h00);
		$display("Test field assembly done");

		for (int k = 0; k < 8; k++) begin
			mm_pulse(OFS[k], 8'(8'h11 * (k + 1)), 1'b1);
		end
		for (int w = 0; w < 4; w++) begin
			@(negedge i_mclk);
			i_expand_width = 2'(w);
			repeat (3) @(negedge i_mclk);
			case (w)
				0: begin
					check(o_fg_color, 32'h0000_0055);
					check(o_bg_color, 32'h0000_0011);
				end
				1: begin
					check(o_fg_color, 32'h0000_6655);
					check(o_bg_color, 32'h0000_2211);
				end
				2: begin
					check(o_fg_color, 32'h0077_6655);
					check(o_bg_color, 32'h0000_0000);
				end
				default: begin
					check(o_fg_color, 32'h8877_6655);
					check(o_bg_color, 32'h4433_2211);
				end
			endcase
		end
		$display("Test colour steering done");

		// Unmapped places take nothing and leave stored values alone
		mm_pulse(8'h13, 8'h77, 1'b1);
		mm_pulse(8'h17, 8'h77, 1'b1);
		io_wr(8'h02, 8'h77);
		io_wr(8'h2B, 8'h77);
		mm_rd(8'h13, rd);
		check(32'(rd), 32'h0);
		io_rd(8'h2B, rd);
		check(32'(rd), 32'h0);
		check(o_fg_color, 32'h8877_6655);
		check(o_bg_color, 32'h4433_2211);
		check(32'(o_width), 32'h0);
		io_pulse(bpr_pkg::IO_INDEX_PORT, 8'h24, 1'b1);
		io_pulse(bpr_pkg::IO_INDEX_PORT, 8'h00, 1'b0);
		@(negedge i_mclk);
		check(32'(o_io_rdata), 32'h24);
		$display("Test unmapped access done");

		// Write then read one byte with no idle cycle between
		@(negedge i_mclk);
		i_mm_addr = 8'h0E;
		i_mm_wdata = 8'h9C;
		i_mm_wr = 1'b1;
		@(negedge i_mclk);
		i_mm_wr = 1'b0;
		i_mm_rd = 1'b1;
		@(negedge i_mclk);
		i_mm_rd = 1'b0;
		check(32'(o_mm_rdata), 32'h9C);
		check(32'(o_src_pitch), 32'h009C);
		$display("Test back-to-back access done");
		end_sim();
	end

endmodule

`default_nettype wire
